// ---- hw/sld_driver.sv ----
`timescale 1ns/10ps
// Functional notes
// - Rising shift clock edge captures serial input into the first stage.
// - Later rising edges move each bit onward; last stage drives serial out.
// - Eight shift stages and eight latches, each latch feeding one output.
// - Strobe high copies each shift stage into its latch.
// - Latches follow the register while strobe high, hold while low.
// - Output disable high turns all drivers off, storage untouched.
// - Output disable low lets each driver show its own latch.
// - Serial out feeds the next device's serial in for cascading.
module sld_driver
  import sld_pkg::*;
#(
  parameter int STAGES = sld_pkg::SLD_STAGES
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Host serial controls
  input  wire sld_pkg::sld_ctrl_type ctrl,
  // Parallel word tap for a receiver, with stall
  output logic                       word_valid,
  input  wire logic                  word_ready,
  output logic [STAGES-1:0]          word_data,
  // Cascade and drivers
  output logic                       ser_out,
  output logic [STAGES-1:0]          sink_on
);
  import sld_pkg::*;

  // The cascade tap and the last-stage index are fixed to eight stages
  if (STAGES != SLD_STAGES) begin : g_bad_stages
    $error("only eight stages supported");
  end

  typedef struct packed {
    logic [STAGES-1:0] shreg;
    logic [STAGES-1:0] latch;
    logic [STAGES-1:0] drive;
    logic              clk_prev;
    logic              ser;
    logic              pend;
    // Registered word tap toward the receiver
    logic              tap_valid;
    logic [STAGES-1:0] tap_data;
  } sld_state_type;

  sld_state_type st_ff;
  sld_state_type nxt_st;
  logic          rise;
  logic          buf_ready;
  logic          buf_valid;
  logic [STAGES-1:0] buf_data;
  logic          tap_free;

  assign rise = ctrl.shift_clk && !st_ff.clk_prev;
  // The tap only pulls from the buffer when its own register is free or being read
  assign tap_free = !st_ff.tap_valid || word_ready;

  always_comb begin
    nxt_st          = st_ff;
    nxt_st.clk_prev = ctrl.shift_clk;
    if (rise) begin
      nxt_st.shreg = {st_ff.shreg[STAGES-2:0], ctrl.ser_in};
    end
    // Without a rise, the shift register keeps its bits.
    nxt_st.ser = nxt_st.shreg[SLD_LAST_POS];
    // Transparent latch: the strobe passes the updated register straight on
    if (ctrl.strobe) begin
      nxt_st.latch = nxt_st.shreg;
    end
    // Disable only gates drivers; latch and register are left alone
    if (ctrl.out_disable) begin
      nxt_st.drive = '0;
    end else begin
      nxt_st.drive = nxt_st.latch;
    end
    // Offer each freshly latched word to the receiver; a stall holds it.
    // One pending flag only: a strobe held high offers a word every other cycle.
    nxt_st.pend = (st_ff.pend && !buf_ready) || (ctrl.strobe && !st_ff.pend);
    // Output register of the tap; a word leaves the buffer only when it lands here
    if (tap_free) begin
      nxt_st.tap_valid = buf_valid;
      nxt_st.tap_data  = buf_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff          <= '0;
      st_ff.shreg    <= SLD_SHIFT_RST;
      st_ff.latch    <= SLD_LATCH_RST;
      st_ff.clk_prev <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Word tap buffer between latches and receiver
  sld_buf #(.WIDTH(STAGES)) u_buf (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (st_ff.pend),
    .in_ready  (buf_ready),
    .in_data   (st_ff.latch),
    .out_valid (buf_valid),
    .out_ready (tap_free),
    .out_data  (buf_data)
  );

  assign word_valid = st_ff.tap_valid;
  assign word_data  = st_ff.tap_data;
  assign ser_out    = st_ff.ser;
  assign sink_on    = st_ff.drive;

  property p_shift_in;
    @(posedge ref_clk) disable iff (!reset_n)
      rise |=> st_ff.shreg[SLD_FIRST_POS] == $past(ctrl.ser_in);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("first stage missed data");

  property p_shift_on;
    @(posedge ref_clk) disable iff (!reset_n)
      rise |=> st_ff.shreg[STAGES-1:1] == $past(st_ff.shreg[STAGES-2:0]);
  endproperty
  a_shift_on: assert property (p_shift_on) else $error("stages did not advance");

  property p_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      !rise |=> $stable(st_ff.shreg);
  endproperty
  a_hold: assert property (p_hold) else $error("register moved without edge");

  property p_ser_out;
    @(posedge ref_clk) disable iff (!reset_n)
      ser_out == st_ff.shreg[SLD_LAST_POS];
  endproperty
  a_ser_out: assert property (p_ser_out) else $error("serial out not last stage");

  property p_latch_load;
    @(posedge ref_clk) disable iff (!reset_n)
      ctrl.strobe |=> st_ff.latch == st_ff.shreg;
  endproperty
  a_latch_load: assert property (p_latch_load) else $error("latch missed strobe");

  property p_latch_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      !ctrl.strobe |=> $stable(st_ff.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed while closed");

  property p_off;
    @(posedge ref_clk) disable iff (!reset_n)
      ctrl.out_disable |=> sink_on == '0;
  endproperty
  a_off: assert property (p_off) else $error("drivers on while disabled");

  property p_follow;
    @(posedge ref_clk) disable iff (!reset_n)
      !ctrl.out_disable |=> sink_on == st_ff.latch;
  endproperty
  a_follow: assert property (p_follow) else $error("drivers differ from latch");

  // Transparent latch: a strobe in the shifting cycle passes the new bit on at once
  property p_transparent;
    @(posedge ref_clk) disable iff (!reset_n)
      ctrl.strobe && rise |=> st_ff.latch[SLD_FIRST_POS] == $past(ctrl.ser_in);
  endproperty
  a_transparent: assert property (p_transparent) else $error("latch not transparent");

  // The cascade output always presents the bit that the next device will take
  property p_ser_next;
    @(posedge ref_clk) disable iff (!reset_n)
      rise |=> ser_out == $past(st_ff.shreg[SLD_LAST_POS-1]);
  endproperty
  a_ser_next: assert property (p_ser_next) else $error("cascade out skipped");

  property p_ser_hold;
    @(posedge ref_clk) disable iff (!reset_n)
      !rise |=> $stable(ser_out);
  endproperty
  a_ser_hold: assert property (p_ser_hold) else $error("cascade out moved");

  // Blanking must leave both register and latches alone
  property p_off_storage;
    @(posedge ref_clk) disable iff (!reset_n)
      ctrl.out_disable && !ctrl.strobe && !rise
      |=> $stable(st_ff.latch) && $stable(st_ff.shreg);
  endproperty
  a_off_storage: assert property (p_off_storage) else $error("blanking moved storage");

  // Each output is fed by its own latch bit and gated by the common disable only
  for (genvar b = 0; b < STAGES; b++) begin : g_bit
    property p_bit_own;
      @(posedge ref_clk) disable iff (!reset_n)
        ctrl.strobe && !ctrl.out_disable |=> sink_on[b] == st_ff.shreg[b];
    endproperty
    a_bit_own: assert property (p_bit_own) else $error("output bit mismatch");
  end

  // Word tap: an offered word stands until the receiver takes it
  property p_tap_keep;
    @(posedge ref_clk) disable iff (!reset_n)
      word_valid && !word_ready |=> word_valid;
  endproperty
  a_tap_keep: assert property (p_tap_keep) else $error("word withdrawn before taken");

  property p_tap_data;
    @(posedge ref_clk) disable iff (!reset_n)
      word_valid && !word_ready |=> $stable(word_data);
  endproperty
  a_tap_data: assert property (p_tap_data) else $error("word changed before taken");

  // Main scenarios: shifting, transparent follow, blanked load, load pulse, stall
  c_shift: cover property (@(posedge ref_clk) disable iff (!reset_n) rise);
  c_follow: cover property (@(posedge ref_clk) disable iff (!reset_n) ctrl.strobe && rise);
  c_blank: cover property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl.strobe && ctrl.out_disable);
  c_load: cover property (@(posedge ref_clk) disable iff (!reset_n) ctrl.strobe ##1 !ctrl.strobe);
  c_stall: cover property (@(posedge ref_clk) disable iff (!reset_n) !buf_ready);
endmodule // sld_driver

// ---- hw/sld_pkg.sv ----
package sld_pkg;

  // Stage count and reset values
  localparam int          SLD_STAGES     = 8;
  localparam logic [7:0]  SLD_SHIFT_RST  = 8'h00;
  localparam logic [7:0]  SLD_LATCH_RST  = 8'h00;
  // Output stays off after reset until the host enables it
  localparam logic        SLD_OFF_RST    = 1'b1;
  // Positions of the first and last stage
  localparam int          SLD_FIRST_POS  = 0;
  localparam int          SLD_LAST_POS   = 7;

  // Host-side serial controls, all sampled on ref_clk
  typedef struct packed {
    logic shift_clk;
    logic ser_in;
    logic strobe;
    logic out_disable;
  } sld_ctrl_type;

  // Word handed from the shift path into the buffer
  typedef struct packed {
    logic [7:0] bits;
  } sld_word_type;

endpackage

// ---- hw/sld_buf.sv ----
`timescale 1ns/10ps
// Two-entry skid buffer; source stalls when full
module sld_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be positive");
  end

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  wp;
    logic                  rp;
    logic [1:0]            cnt;
  } sld_buf_state_type;

  sld_buf_state_type st_ff;
  sld_buf_state_type nxt_st;
  logic              push;
  logic              pop;

  assign in_ready  = (st_ff.cnt != 2'h2);
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data  = st_ff.mem[st_ff.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wp] = in_data;
      nxt_st.wp            = ~st_ff.wp;
    end
    if (pop) begin
      nxt_st.rp = ~st_ff.rp;
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_no_overflow;
    @(posedge ref_clk) disable iff (!reset_n)
      st_ff.cnt <= 2'h2;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("buffer count out of range");
endmodule // sld_buf

// ---- verification/sld_host.sv ----
`timescale 1ns/10ps
// Host model: bit-bangs the serial lines, first bit ends in the last stage
module sld_host
  import sld_pkg::*;
(
  // Clock
  input  wire logic             ref_clk,
  // Serial lines
  output sld_pkg::sld_ctrl_type ctrl,
  input  wire logic             ser_out
);
  initial ctrl = '{1'b0, 1'b0, 1'b0, 1'b1};
  // Records the cascade output before each rise
  task automatic shift_byte(input logic [7:0] d, output logic [7:0] seen);
    for (int i = 7; i >= 0; i--) begin
      @(negedge ref_clk);
      seen[i] = ser_out;
      @(posedge ref_clk);
      ctrl.ser_in <= d[i];
      ctrl.shift_clk <= 1'b1;
      @(posedge ref_clk);
      ctrl.shift_clk <= 1'b0;
      // Released data line is not left at the sampled level
      ctrl.ser_in <= ~d[i];
      @(posedge ref_clk);
    end
  endtask
  task automatic strobe_pulse();
    @(posedge ref_clk);
    ctrl.strobe <= 1'b1;
    @(posedge ref_clk);
    ctrl.strobe <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic set_lines(input logic strb, input logic dis);
    @(posedge ref_clk);
    ctrl.strobe <= strb;
    ctrl.out_disable <= dis;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule // sld_host

// ---- verification/sld_driver_test.sv ----
`timescale 1ns/10ps
module sld_driver_test;
  import sld_pkg::*;
  typedef struct packed {
    logic [7:0] data;
    logic       strb;
    logic       dis;
    logic [7:0] sink;
  } sld_row_type;
  localparam sld_row_type ROWS [5] = '{
    '{8'ha5, 1'b1, 1'b0, 8'ha5}, '{8'h3c, 1'b0, 1'b0, 8'ha5},
    '{8'hff, 1'b1, 1'b1, 8'h00}, '{8'h81, 1'b0, 1'b0, 8'hff},
    '{8'h00, 1'b1, 1'b0, 8'h00}};
  logic         ref_clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         word_ready = 1'b1;
  logic         word_valid;
  logic [7:0]   word_data;
  logic         ser_out;
  logic [7:0]   sink_on;
  logic [7:0]   prev;
  logic [7:0]   seen;
  sld_ctrl_type ctrl;
  int           failures = 0;
  int           samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  sld_host i_host (.ref_clk(ref_clk), .ctrl(ctrl), .ser_out(ser_out));
  sld_driver #(.STAGES(SLD_STAGES)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .ctrl(ctrl), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .ser_out(ser_out), .sink_on(sink_on));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic take_word(input logic [7:0] exp);
    for (int k = 0; k < 20; k++) begin
      @(negedge ref_clk);
      if (word_valid === 1'b1) break;
    end
    chk("word_data", exp, word_valid ? word_data : 8'hxx);
    @(posedge ref_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run needs well under 2000 cycles
  initial begin
    #20000;
    failures++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    chk("reset", 8'h00, sink_on | word_data | {6'h00, ser_out, word_valid});
    $display("reset test done");
    reset_n <= 1'b1;
    prev = SLD_SHIFT_RST;
    foreach (ROWS[i]) begin
      i_host.set_lines(1'b0, ROWS[i].dis);
      i_host.shift_byte(ROWS[i].data, seen);
      chk("cascade", prev, seen);
      prev = ROWS[i].data;
      if (ROWS[i].strb) i_host.strobe_pulse();
      chk("sink_on", ROWS[i].sink, sink_on);
    end
    $display("table test done");
    i_host.set_lines(1'b1, 1'b1);
    i_host.shift_byte(8'hda, seen);
    chk("sink_on", 8'h00, sink_on);
    i_host.set_lines(1'b1, 1'b0);
    chk("sink_on", 8'hda, sink_on);
    i_host.set_lines(1'b0, 1'b0);
    repeat (20) @(posedge ref_clk);
    chk("ser_out", 8'h01, {7'h00, ser_out});
    $display("transparent and hold test done");
    @(posedge ref_clk);
    word_ready <= 1'b0;
    i_host.shift_byte(8'h11, seen);
    chk("cascade", 8'hda, seen);
    i_host.strobe_pulse();
    i_host.shift_byte(8'h22, seen);
    chk("cascade", 8'h11, seen);
    i_host.strobe_pulse();
    i_host.shift_byte(8'h33, seen);
    chk("cascade", 8'h22, seen);
    i_host.strobe_pulse();
    @(posedge ref_clk);
    word_ready <= 1'b1;
    take_word(8'h11);
    take_word(8'h22);
    take_word(8'h33);
    $display("stall test done");
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("reset", 8'h00, sink_on | word_data | {6'h00, ser_out, word_valid});
    reset_n <= 1'b1;
    i_host.shift_byte(8'h5a, seen);
    chk("cascade", 8'h00, seen);
    i_host.strobe_pulse();
    chk("sink_on", 8'h5a, sink_on);
    $display("mid-run reset test done");
    final_report();
  end
endmodule // sld_driver_test
